//--- design/reset_boot_config_consts.svh
// constants for the reset configuration and bus clock ratio block
// assumes a 200 MHz mclk and a plain one-cycle register port
`ifndef RESET_BOOT_CONFIG_CONSTS_SVH
`define RESET_BOOT_CONFIG_CONSTS_SVH

// register offsets (byte addresses on the register port)
`define OFF_INTEG_CFG 8'h00
`define OFF_MACH_B_MODE 8'h04
`define OFF_PA_ASSIGN 8'h08
`define OFF_PA_DIR 8'h0C
`define OFF_PB_ASSIGN 8'h10
`define OFF_PB_DIR 8'h14
`define OFF_PC_ASSIGN 8'h18
`define OFF_PC_DIR 8'h1C
`define OFF_STATUS 8'h20
`define OFF_CFG_WORD 8'h24

// integration module configuration register fields
`define CFG_DBG_LSB 0
`define CFG_DBG_MSB 1
`define CFG_HALF_BIT 2
`define CFG_ALIGN_BIT 3
// machine B mode register: line 4 disable bit
`define MB_LINE4_DIS_BIT 0
// status register fields
`define ST_USE_WORD_BIT 0
`define ST_HARD_RESET_BIT 1
`define ST_CONFIG_OK_BIT 2
`define ST_HALF_BIT 3

// reset values
`define DBG_RESET 2'h0
`define ALIGN_RESET 1'b1
`define MB_RESET 32'h0000_0001
`define PORT_RESET 16'h0000
// port A bits 5..9 and 12..13, bit 0 being the msb of 16
`define PA_ZERO_MASK 16'h07CC
// debug field pattern X1: only the low bit is checked
`define DBG_REQ_MASK 2'h1

// bus clock limits and rate
`define BUS_MAX_MHZ 80
`define MCLK_MHZ 200

`endif

//--- design/reset_boot_config_pkg.sv
// types for the reset configuration and bus clock ratio block
// assumes the constants header is included by the design file
package reset_boot_config_pkg;

    // word presented on the data pins during hard reset
    typedef struct packed {
        logic [28:0] spare;
        logic half_speed;
        logic [1:0] debug_pin_config_field;
    } hard_reset_config_word_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : reset_boot_config_pkg

//--- design/reset_boot_config.sv
// reset configuration capture, boot register set and bus clock ratio
// assumes pins arrive asynchronous to mclk and software uses the plain port
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "reset_boot_config_consts.svh"

module reset_boot_config #(
    parameter int CORE_MHZ = 133,
    parameter int PORT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hard_reset_pin_b,
    input wire logic reset_config_select_pin_b,
    input wire reset_boot_config_pkg::hard_reset_config_word_t hard_reset_config_word,
    input wire logic external_ref_clock,
    input wire reset_boot_config_pkg::reg_req_t req,
    output logic [31:0] rdata,
    output logic bus_clock_output,
    output logic use_word,
    output logic half_speed_active,
    output logic config_ok
);

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [1:0] hr_sync_reg;
    logic [1:0] sel_sync_reg;
    logic [2:0] ref_sync_reg;
    reset_boot_config_pkg::hard_reset_config_word_t word_s1_reg;
    reset_boot_config_pkg::hard_reset_config_word_t word_s2_reg;
    logic hr_act;
    logic hr_prev_reg;
    logic hr_fall;
    logic cfg_sample_reg;
    logic use_word_reg;
    reset_boot_config_pkg::hard_reset_config_word_t word_cap_reg;
    logic [1:0] dbg_reg;
    logic half_req_reg;
    logic align_reg;
    logic [31:0] mb_reg;
    logic [PORT_W-1:0] pa_asg_reg, pa_dir_reg, pb_asg_reg, pb_dir_reg, pc_asg_reg, pc_dir_reg;
    logic half_reg;
    logic ok_reg;
    logic ok_next;
    logic ref_rise;
    logic align_evt;
    logic div_reg;
    logic bus_clk_reg;
    logic [31:0] rdata_reg;
    logic sw_wr;

    localparam logic HALF_FORCED = (CORE_MHZ > `BUS_MAX_MHZ);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // pin synchronisers; the second stage is read, and for the reference edge the third stage as well
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hr_sync_reg <= 2'h0; // reads as asserted, so no false release after reset
            sel_sync_reg <= 2'h3;
            ref_sync_reg <= 3'h0;
            word_s1_reg <= '0;
            word_s2_reg <= '0;
        end else begin
            hr_sync_reg <= {hr_sync_reg[0], hard_reset_pin_b};
            sel_sync_reg <= {sel_sync_reg[0], reset_config_select_pin_b};
            ref_sync_reg <= {ref_sync_reg[1:0], external_ref_clock};
            word_s1_reg <= hard_reset_config_word;
            word_s2_reg <= word_s1_reg;
        end
    end

    assign hr_act = !hr_sync_reg[1];
    assign hr_fall = hr_prev_reg && !hr_act;
    assign ref_rise = ref_sync_reg[1] && !ref_sync_reg[2];
    assign align_evt = align_reg && ref_rise;
    // software writes are refused while hard reset is asserted
    assign sw_wr = req.wr && !hr_act;

    // sample the select level during hard reset, hold it after release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hr_prev_reg <= 1'b1;
            cfg_sample_reg <= 1'b0;
            use_word_reg <= 1'b0;
            word_cap_reg <= '0;
        end else begin
            hr_prev_reg <= hr_act;
            if (hr_act) begin
                cfg_sample_reg <= !sel_sync_reg[1];
                word_cap_reg <= word_s2_reg;
            end
            if (hr_fall) begin
                use_word_reg <= cfg_sample_reg;
            end
        end
    end

    // integration module configuration register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_reg <= `DBG_RESET;
            half_req_reg <= 1'b0;
            align_reg <= `ALIGN_RESET;
        end else if (hr_fall) begin
            if (cfg_sample_reg) begin
                dbg_reg <= word_cap_reg.debug_pin_config_field;
                half_req_reg <= word_cap_reg.half_speed;
            end else begin
                dbg_reg <= `DBG_RESET;
                half_req_reg <= 1'b0;
            end
        end else if (sw_wr && req.addr == `OFF_INTEG_CFG) begin
            dbg_reg <= req.wdata[`CFG_DBG_MSB:`CFG_DBG_LSB];
            half_req_reg <= req.wdata[`CFG_HALF_BIT];
            align_reg <= req.wdata[`CFG_ALIGN_BIT];
        end
    end

    // machine B mode and port registers, written by boot code
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mb_reg <= `MB_RESET;
            pa_asg_reg <= `PORT_RESET;
            pa_dir_reg <= `PORT_RESET;
            pb_asg_reg <= `PORT_RESET;
            pb_dir_reg <= `PORT_RESET;
            pc_asg_reg <= `PORT_RESET;
            pc_dir_reg <= `PORT_RESET;
        end else if (sw_wr) begin
            case (req.addr)
                `OFF_MACH_B_MODE: mb_reg <= req.wdata;
                `OFF_PA_ASSIGN: pa_asg_reg <= req.wdata[PORT_W-1:0];
                `OFF_PA_DIR: pa_dir_reg <= req.wdata[PORT_W-1:0];
                `OFF_PB_ASSIGN: pb_asg_reg <= req.wdata[PORT_W-1:0];
                `OFF_PB_DIR: pb_dir_reg <= req.wdata[PORT_W-1:0];
                `OFF_PC_ASSIGN: pc_asg_reg <= req.wdata[PORT_W-1:0];
                `OFF_PC_DIR: pc_dir_reg <= req.wdata[PORT_W-1:0];
                default: ;
            endcase
        end
    end

    // mandatory boot settings all present
    always_comb begin
        ok_next = !hr_act
            && ((dbg_reg & `DBG_REQ_MASK) == `DBG_REQ_MASK)
            && (!use_word_reg || dbg_reg == word_cap_reg.debug_pin_config_field)
            && !mb_reg[`MB_LINE4_DIS_BIT]
            && ((pa_asg_reg & `PA_ZERO_MASK) == `PORT_RESET);
    end

    // a core above the bus limit forces half speed whatever software asks
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            half_reg <= 1'b1;
            ok_reg <= 1'b0;
        end else begin
            half_reg <= HALF_FORCED || half_req_reg;
            ok_reg <= ok_next;
        end
    end

    // bus clock: mclk/2 at 1:1, mclk/4 at half speed; the synchronised
    // reference edge lags the pin by two mclk cycles, inside phase tolerance
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 1'b0;
            bus_clk_reg <= 1'b0;
        end else if (align_evt) begin
            div_reg <= 1'b0;
            bus_clk_reg <= 1'b1;
        end else if (half_reg) begin
            div_reg <= !div_reg;
            if (div_reg) begin
                bus_clk_reg <= !bus_clk_reg;
            end
        end else begin
            div_reg <= 1'b0;
            bus_clk_reg <= !bus_clk_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (req.rd) begin
            case (req.addr)
                `OFF_INTEG_CFG: rdata_reg <= {28'h0, align_reg, half_req_reg, dbg_reg};
                `OFF_MACH_B_MODE: rdata_reg <= mb_reg;
                `OFF_PA_ASSIGN: rdata_reg <= 32'(pa_asg_reg);
                `OFF_PA_DIR: rdata_reg <= 32'(pa_dir_reg);
                `OFF_PB_ASSIGN: rdata_reg <= 32'(pb_asg_reg);
                `OFF_PB_DIR: rdata_reg <= 32'(pb_dir_reg);
                `OFF_PC_ASSIGN: rdata_reg <= 32'(pc_asg_reg);
                `OFF_PC_DIR: rdata_reg <= 32'(pc_dir_reg);
                `OFF_STATUS: rdata_reg <= {28'h0, half_reg, ok_reg, hr_act, use_word_reg};
                `OFF_CFG_WORD: rdata_reg <= word_cap_reg;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign rdata = rdata_reg;
    assign bus_clock_output = bus_clk_reg;
    assign use_word = use_word_reg;
    assign half_speed_active = half_reg;
    assign config_ok = ok_reg;

    sequence s_release;
        hr_prev_reg ##0 !hr_act;
    endsequence

    sequence s_half_tick;
        half_reg && !align_evt && div_reg;
    endsequence

    property p_choice_latched;
        @(posedge mclk) disable iff (!rst_n)
        s_release |=> use_word_reg == $past(cfg_sample_reg);
    endproperty
    a_choice_latched: assert property (p_choice_latched) else $error("choice not latched");

    property p_choice_held;
        @(posedge mclk) disable iff (!rst_n)
        (!hr_act && !hr_prev_reg) |=> $stable(use_word_reg);
    endproperty
    a_choice_held: assert property (p_choice_held) else $error("choice moved");

    property p_word_used;
        @(posedge mclk) disable iff (!rst_n)
        (s_release ##0 cfg_sample_reg) |=> dbg_reg == $past(word_cap_reg.debug_pin_config_field);
    endproperty
    a_word_used: assert property (p_word_used) else $error("word field not loaded");

    property p_word_ignored;
        @(posedge mclk) disable iff (!rst_n)
        (s_release ##0 !cfg_sample_reg) |=> dbg_reg == `DBG_RESET && !half_req_reg;
    endproperty
    a_word_ignored: assert property (p_word_ignored) else $error("word used when off");

    property p_half_forced;
        @(posedge mclk) disable iff (!rst_n)
        HALF_FORCED |-> half_reg;
    endproperty
    a_half_forced: assert property (p_half_forced) else $error("fast core at full bus");

    property p_half_rate;
        @(posedge mclk) disable iff (!rst_n)
        (half_reg && !align_evt && !div_reg) ##1 s_half_tick |=> $changed(bus_clk_reg);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half rate wrong");

    property p_full_rate;
        @(posedge mclk) disable iff (!rst_n)
        (!half_reg && !align_evt) |=> bus_clk_reg != $past(bus_clk_reg);
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("full rate wrong");

    property p_align;
        @(posedge mclk) disable iff (!rst_n)
        align_evt |=> bus_clk_reg && !div_reg;
    endproperty
    a_align: assert property (p_align) else $error("edge not aligned");

    property p_write_blocked;
        @(posedge mclk) disable iff (!rst_n)
        (hr_act && req.wr) |=> $stable({mb_reg, pa_asg_reg, pa_dir_reg, pb_asg_reg})
            && $stable({pb_dir_reg, pc_asg_reg, pc_dir_reg});
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("write in hard reset");

    property p_status_read;
        @(posedge mclk) disable iff (!rst_n)
        (req.rd && req.addr == `OFF_STATUS) |=> rdata[`ST_USE_WORD_BIT] == $past(use_word_reg);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

endmodule : reset_boot_config

`default_nettype wire

//--- verif/board_reset_model.sv
// board reset logic model: hard reset, select pin, config word, reference clock
// assumes the bench raises hold_reset and picks select level and debug msb
`timescale 1ns/1ps
`default_nettype none

module board_reset_model (
    input wire logic mclk,
    input wire logic hold_reset,
    input wire logic want_word,
    input wire logic dbg_hi,
    output logic hard_reset_pin_b,
    output logic reset_config_select_pin_b,
    output var reset_boot_config_pkg::hard_reset_config_word_t hard_reset_config_word,
    output logic external_ref_clock
);
    logic [3:0] hold_cnt;

    initial begin
        external_ref_clock = 1'b0;
        hard_reset_pin_b = 1'b0;
        reset_config_select_pin_b = 1'b0;
        hard_reset_config_word = 32'h0000_0001;
        hold_cnt = 4'h8;
    end

    // reference runs free; 16 mclk keeps the bus ratio an integer
    always #40 external_ref_clock = ~external_ref_clock;

    always @(posedge mclk) begin
        if (hold_reset) begin
            hold_cnt <= 4'h8;
            hard_reset_pin_b <= 1'b0;
            reset_config_select_pin_b <= ~want_word;
            hard_reset_config_word <= {29'h0, 1'b0, dbg_hi, 1'b1};
        end else if (hold_cnt != 4'h0) begin
            hold_cnt <= hold_cnt - 4'h1; // pins stand stable before release
        end else begin
            hard_reset_pin_b <= 1'b1;
            // released lines: select flips, data toggles every cycle
            reset_config_select_pin_b <= want_word;
            hard_reset_config_word <= ~hard_reset_config_word;
        end
    end
endmodule : board_reset_model

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the reset configuration block
// assumes default parameters (133 MHz core) and the board model beside it
`timescale 1ns/1ps
`default_nettype none
`include "reset_boot_config_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic hold_reset = 1'b1;
    logic want_word = 1'b1;
    logic dbg_hi = 1'b0;
    logic hard_reset_pin_b, reset_config_select_pin_b, external_ref_clock;
    reset_boot_config_pkg::hard_reset_config_word_t hard_reset_config_word;
    reset_boot_config_pkg::reg_req_t req = '0;
    logic [31:0] rdata;
    logic [31:0] rnd = 32'h0000_0032;
    logic bus_clock_output, use_word, half_speed_active, config_ok;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int mdl[int];
    bit m_hr = 1'b1;
    bit m_use = 1'b0;
    bit [1:0] m_fld = 2'h0;

    always #2.5 mclk = ~mclk;

    board_reset_model i_board (.mclk(mclk), .hold_reset(hold_reset), .want_word(want_word),
        .dbg_hi(dbg_hi), .hard_reset_pin_b(hard_reset_pin_b),
        .reset_config_select_pin_b(reset_config_select_pin_b),
        .hard_reset_config_word(hard_reset_config_word),
        .external_ref_clock(external_ref_clock));

    reset_boot_config i_dut (.mclk(mclk), .rst_b(rst_b), .hard_reset_pin_b(hard_reset_pin_b),
        .reset_config_select_pin_b(reset_config_select_pin_b),
        .hard_reset_config_word(hard_reset_config_word),
        .external_ref_clock(external_ref_clock), .req(req), .rdata(rdata),
        .bus_clock_output(bus_clock_output), .use_word(use_word),
        .half_speed_active(half_speed_active), .config_ok(config_ok));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic bit m_ok();
        return !m_hr && mdl[0][0] && !mdl[4][0] && ((mdl[8] & `PA_ZERO_MASK) == 0)
            && (!m_use || mdl[0][1:0] == m_fld);
    endfunction : m_ok

    function automatic logic [31:0] m_status();
        return {28'h0, 1'b1, m_ok(), m_hr, m_use};
    endfunction : m_status

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge mclk);
        req.wr <= 1'b0;
        if (!m_hr && a <= 8'h1C) mdl[a] = (a >= 8'h08) ? (d & 32'h0000_FFFF) : d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
        @(posedge mclk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        `CHK(rdata & msk, e & msk)
    endtask : rd

    task automatic settle_ok();
        repeat (3) @(posedge mclk);
        #1;
        `CHK(config_ok, m_ok())
    endtask : settle_ok

    task automatic hard_reset_pin(input bit use_w, input bit hi);
        hold_reset <= 1'b1;
        want_word <= use_w;
        dbg_hi <= hi;
        m_hr = 1'b1;
        repeat (6) @(posedge mclk);
        rd(8'h20, 32'h0000_000F, m_status());
        wr(8'h04, 32'h0000_0000);
        rd(8'h04, 32'hFFFF_FFFF, mdl[4]);
        @(posedge mclk);
        hold_reset <= 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        m_hr = 1'b0;
        m_use = use_w;
        m_fld = {hi, 1'b1};
        mdl[0] = (mdl[0] & 32'hC) | (use_w ? {30'h0, hi, 1'b1} : 32'h0);
        `CHK(use_word, use_w)
        `CHK(half_speed_active, 1'b1)
        settle_ok();
        rd(8'h20, 32'h0000_000F, m_status());
        rd(8'h00, 32'h0000_000B, mdl[0]);
    endtask : hard_reset_pin

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        int tog;
        logic prev;
        for (int a = 0; a <= 32'h1C; a += 4) mdl[a] = 0;
        mdl[0] = 32'h8;
        mdl[4] = 1;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        hard_reset_pin(1'b1, 1'b0);
        rd(8'h24, 32'hFFFF_FFFF, 32'h0000_0001);
        wr(8'h04, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            wr(8'h08 + 8'(8 * i), rnd);
            wr(8'h0C + 8'(8 * i), ~rnd);
        end
        for (int a = 0; a <= 32'h1C; a += 4)
            rd(8'(a), (a == 0) ? 32'h0000_000B : 32'hFFFF_FFFF, mdl[a]);
        settle_ok();
        wr(8'h08, mdl[8] & ~`PA_ZERO_MASK);
        settle_ok();
        // debug field differing from the captured word must drop config_ok
        wr(8'h00, 32'h0000_000B);
        settle_ok();
        rd(8'h28, 32'hFFFF_FFFF, 32'h0000_0000);
        // alignment off so the divider runs undisturbed while counting
        wr(8'h00, 32'h0000_0001);
        tog = 0;
        #1;
        prev = bus_clock_output;
        repeat (32) begin
            @(posedge mclk);
            #1;
            if (bus_clock_output !== prev) tog++;
            prev = bus_clock_output;
        end
        `CHK(tog, 16)
        hard_reset_pin(1'b0, 1'b1);
        for (int d = 0; d < 4; d++) begin
            wr(8'h00, 32'h0000_0008 | d);
            settle_ok();
        end
        repeat (2) begin
            @(posedge external_ref_clock);
            repeat (4) @(posedge mclk);
            #1;
            `CHK(bus_clock_output, 1'b1)
            repeat (2) @(posedge mclk);
            #1;
            `CHK(bus_clock_output, 1'b0)
        end
        summarize();
    end
endmodule : tb_top

`default_nettype wire
